// File: hw/usc_top.sv
// Serial port status and control core with APB register slave
`timescale 1ns/1ps
module usc_top import usc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  output logic irq
);
  usc_line_if lnk();
  logic [1:0] txm_r;
  logic [1:0] rxm_r;
  logic inv_r;
  logic brk_r;
  logic en_r;
  logic address_detect_enable_r;
  logic rx_overrun_flag_r;
  logic infrared_encode_enable_r;
  logic [15:0] div_r;
  logic [15:0] dcnt_r;
  logic tick_r;
  logic [2:0] ist_r;
  logic [2:0] imsk_r;
  logic [7:0] txb_r [BUF_DEPTH];
  logic [8:0] rxb_r [BUF_DEPTH];
  logic [1:0] twp_r;
  logic [1:0] trp_r;
  logic [1:0] rwp_r;
  logic [1:0] rrp_r;
  logic [2:0] tcnt_r;
  logic [2:0] rcnt_r;
  logic rs1_r;
  logic rs2_r;
  logic pin_r;
  logic oe_r;
  logic [31:0] prdata_r;

  // Bus decode
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_sta = paddr == OFF_STA;
  wire hit_txd = paddr == OFF_TXD;
  wire hit_rxd = paddr == OFF_RXD;
  wire hit_ctl = paddr == OFF_CTL;
  wire hit_ist = paddr == OFF_IST;
  wire hit_imsk = paddr == OFF_IMSK;
  wire mapped = hit_sta || hit_txd || hit_rxd || hit_ctl || hit_ist ||
                hit_imsk;
  wire wr_sta = wr && hit_sta;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;

  // Transmit side
  wire tx_full = tcnt_r == BUF_FULL;
  // Writes to a full buffer are dropped silently
  wire tx_push = wr && hit_txd && en_r && !tx_full;
  wire tx_pop = lnk.tx_valid && lnk.tx_ready;
  wire [2:0] tcnt_nxt = !en_r ? 3'h0 :
                        tcnt_r + {2'h0, tx_push} - {2'h0, tx_pop};
  wire tx_shift_empty = tcnt_r == 3'h0 && !lnk.tx_busy;
  wire ev_char = txm_r == TXM_CHAR && tx_pop;
  wire ev_empty = txm_r == TXM_EMPTY && tx_pop && tcnt_nxt == 3'h0;
  wire ev_done = txm_r == TXM_DONE && lnk.tx_done &&
                 tcnt_r == 3'h0;
  // Reserved mode 11 raises no transmit event at all
  wire tx_ev = ev_char || ev_empty || ev_done;
  wire brk_clr = lnk.tx_done && lnk.tx_brk_act;
  // A fresh software write of the break bit beats the hardware clear
  wire brk_nxt = wr_sta ? pwdata[B_BRK] : brk_r && !brk_clr;
  wire ir_low = !lnk.tx_raw && lnk.tx_slot;
  wire ir_pin = inv_r ? !ir_low : ir_low;
  wire pin_nxt = infrared_encode_enable_r ? ir_pin : lnk.tx_raw ^ inv_r;

  // Receive side
  wire rx_full = rcnt_r == BUF_FULL;
  wire rx_pop = rd && hit_rxd && rcnt_r != 3'h0;
  wire rx_push = lnk.rx_valid && !rx_full;
  wire rx_ovf = lnk.rx_valid && rx_full;
  wire [2:0] rcnt_nxt = rcnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
  wire ev_any = rx_push && !rxm_r[1];
  wire ev_3q = rx_push && rxm_r == RXM_3Q && rcnt_nxt == BUF_3Q;
  wire ev_rfull = rx_push && rxm_r == RXM_FULL &&
                  rcnt_nxt == BUF_FULL;
  wire rx_ev = ev_any || ev_3q || ev_rfull;
  wire rda = rcnt_r != 3'h0;
  wire [8:0] rx_head = rxb_r[rrp_r];
  // Set wins over the clear, so no lost character goes unreported
  wire rx_overrun_flag_nxt = rx_ovf || (rx_overrun_flag_r && !(wr_sta && !pwdata[B_RX_OVERRUN_FLAG]));

  // Interrupt status, write one to clear, set wins
  wire [2:0] ev = {rx_ovf, rx_ev, tx_ev};
  wire [2:0] ist_w1c = (wr && hit_ist) ? pwdata[2:0] : 3'h0;
  wire [2:0] ist_nxt = ev | (ist_r & ~ist_w1c);
  assign irq = |(ist_r & imsk_r);

  // Read path; parity is not supported so its flag reads zero
  wire [15:0] sta_word = {txm_r[1], inv_r, txm_r[0], 1'b0,
                          brk_r, en_r, tx_full, tx_shift_empty,
                          rxm_r, address_detect_enable_r, lnk.rx_idle, 1'b0,
                          rx_head[8] && rda, rx_overrun_flag_r, rda};
  wire [31:0] rd_word = hit_sta ? {16'h0000, sta_word} :
                        hit_rxd ? {24'h000000, rx_head[7:0]} :
                        hit_ctl ? {15'h0000, infrared_encode_enable_r, div_r} :
                        hit_ist ? {29'h00000000, ist_r} :
                        hit_imsk ? {29'h00000000, imsk_r} : 32'h00000000;

  assign lnk.tick = tick_r;
  assign lnk.tx_valid = en_r && tcnt_r != 3'h0;
  assign lnk.tx_data = txb_r[trp_r];
  assign lnk.tx_brk = brk_r;
  assign lnk.tx_abort = !en_r;
  assign lnk.rx_line = rs2_r;
  assign serial_tx_pin = pin_r;
  assign serial_tx_oe = oe_r;

  usc_tx_engine u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.txe)
  );

  usc_rx_engine u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.rxe)
  );

  // Oversample tick divider, one pulse every div_r + 1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= dcnt_r == div_r;
      dcnt_r <= (dcnt_r >= div_r) ? 16'h0000 : dcnt_r + 16'h0001;
    end
  end

  // Pin side flops; receive line is asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs1_r <= 1'b1;
      rs2_r <= 1'b1;
      pin_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      rs1_r <= serial_rx_pin;
      rs2_r <= rs1_r;
      pin_r <= pin_nxt;
      oe_r <= en_r;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txm_r <= 2'h0;
      rxm_r <= 2'h0;
      inv_r <= 1'b0;
      en_r <= 1'b0;
      address_detect_enable_r <= 1'b0;
      infrared_encode_enable_r <= 1'b0;
      div_r <= DIV_RESET;
      imsk_r <= 3'h0;
    end else if (wr && hit_sta) begin
      txm_r <= {pwdata[B_TXM1], pwdata[13]};
      inv_r <= pwdata[14];
      en_r <= pwdata[10];
      rxm_r <= pwdata[7:6];
      address_detect_enable_r <= pwdata[5];
    end else if (wr && hit_ctl) begin
      div_r <= pwdata[15:0];
      infrared_encode_enable_r <= pwdata[B_INFRARED_ENCODE_ENABLE];
    end else if (wr && hit_imsk) begin
      imsk_r <= pwdata[2:0];
    end
  end

  // Flags, counters and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= 1'b0;
      rx_overrun_flag_r <= 1'b0;
      ist_r <= 3'h0;
      tcnt_r <= 3'h0;
      rcnt_r <= 3'h0;
      twp_r <= 2'h0;
      trp_r <= 2'h0;
      rwp_r <= 2'h0;
      rrp_r <= 2'h0;
      prdata_r <= 32'h00000000;
    end else begin
      brk_r <= brk_nxt;
      rx_overrun_flag_r <= rx_overrun_flag_nxt;
      ist_r <= ist_nxt;
      tcnt_r <= tcnt_nxt;
      rcnt_r <= rcnt_nxt;
      twp_r <= !en_r ? 2'h0 : twp_r + {1'b0, tx_push};
      trp_r <= !en_r ? 2'h0 : trp_r + {1'b0, tx_pop};
      rwp_r <= rwp_r + {1'b0, rx_push};
      rrp_r <= rrp_r + {1'b0, rx_pop};
      if (setup) prdata_r <= rd_word;
    end
  end

  // Buffer storage needs no reset
  always_ff @(posedge pclk) begin
    if (tx_push) txb_r[twp_r] <= pwdata[7:0];
    if (rx_push) rxb_r[rwp_r] <= {lnk.rx_rx_framing_error, lnk.rx_data};
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mode10_irq: assert property (
    (txm_r == TXM_EMPTY && tx_pop && tcnt_r == 3'h1 && !tx_push)
    |=> ist_r[IRQ_TX]) else $error("mode 10 irq missing");
  chk_mode01_irq: assert property (
    (txm_r == TXM_DONE && lnk.tx_done && tcnt_r == 3'h0 && !tx_push)
    |=> (ist_r[IRQ_TX] && tx_shift_empty)) else $error("mode 01 irq missing");
  chk_mode00_irq: assert property (
    (txm_r == TXM_CHAR && tx_pop) |=> ist_r[IRQ_TX])
    else $error("mode 00 irq missing");
  chk_plain_idle: assert property (
    (!lnk.tx_busy && !infrared_encode_enable_r) [*2] |=> (serial_tx_pin == !$past(inv_r)))
    else $error("plain idle level wrong");
  chk_ir_idle: assert property (
    (!lnk.tx_busy && infrared_encode_enable_r) [*2] |=> (serial_tx_pin == $past(inv_r)))
    else $error("infrared idle level wrong");
  chk_break_clear: assert property (
    (brk_clr && !wr_sta) |=> !brk_r) else $error("break not cleared");
  chk_break_len: assert property (
    (tx_pop && brk_r) |=> lnk.tx_brk_act [*8])
    else $error("break frame dropped early");
  chk_disable_flush: assert property (
    !en_r |=> (tcnt_r == 3'h0 && !serial_tx_oe && !lnk.tx_busy))
    else $error("disable did not flush");
  chk_full_flag: assert property (
    (tcnt_r == BUF_FULL) |-> (sta_word[B_FULL] && !tx_push))
    else $error("full flag or push wrong");
  chk_tx_shift_empty_read: assert property (
    (setup && hit_sta && lnk.tx_busy) |=> !prdata[B_TX_SHIFT_EMPTY])
    else $error("shifter empty read while busy");
  chk_rx_full_irq: assert property (
    (rxm_r == RXM_FULL && rx_push && rcnt_r == BUF_3Q && !rx_pop)
    |=> ist_r[IRQ_RX]) else $error("rx full irq missing");
  chk_rx_3q_irq: assert property (
    (rxm_r == RXM_3Q && rx_push && rcnt_r == 3'h2 && !rx_pop)
    |=> ist_r[IRQ_RX]) else $error("rx 3q irq missing");
  chk_rx_any_irq: assert property (
    (!rxm_r[1] && rx_push) |=> ist_r[IRQ_RX])
    else $error("rx any irq missing");
  chk_bit12_zero: assert property (
    (setup && hit_sta) |=> !prdata[B_RSV]) else $error("bit 12 not zero");
  chk_overrun_set: assert property (
    (lnk.rx_valid && rx_full && !rx_pop) |=> (rx_overrun_flag_r && rx_full))
    else $error("overrun not flagged");
  chk_overrun_clear: assert property (
    (wr_sta && !pwdata[B_RX_OVERRUN_FLAG] && !rx_ovf) |=> !rx_overrun_flag_r)
    else $error("overrun not cleared by zero");
  chk_break_set: assert property (
    (wr_sta && pwdata[B_BRK]) |=> brk_r)
    else $error("break request lost");
  chk_oe_follow: assert property (
    en_r |=> serial_tx_oe)
    else $error("output enable not driven");
  chk_tx_shift_empty_flag: assert property (
    (tcnt_r != 3'h0 || lnk.tx_busy) |-> !sta_word[B_TX_SHIFT_EMPTY])
    else $error("shifter empty flag set while busy");
  chk_not_full: assert property (
    (tcnt_r != BUF_FULL) |-> !sta_word[B_FULL])
    else $error("full flag set with a free slot");

  cov_break_sent: cover property (tx_pop && brk_r ##[1:1000] brk_clr);
  cov_overrun: cover property (rx_ovf);
  cov_done_irq: cover property (ev_done);
  cov_irq_rise: cover property ($rose(irq));
  cov_rx_full: cover property (ev_rfull);
endmodule

// File: hw/usc_pkg.sv
// Shared constants and types for the serial status and control block
package usc_pkg;
  localparam logic [7:0] OFF_STA = 8'h00;
  localparam logic [7:0] OFF_TXD = 8'h04;
  localparam logic [7:0] OFF_RXD = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_IST = 8'h10;
  localparam logic [7:0] OFF_IMSK = 8'h14;
  localparam int B_TXM1 = 15;
  localparam int B_TX_SHIFT_EMPTY = 8;
  localparam int B_FULL = 9;
  localparam int B_BRK = 11;
  localparam int B_RSV = 12;
  localparam int B_RX_OVERRUN_FLAG = 1;
  localparam int B_INFRARED_ENCODE_ENABLE = 16;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_OVR = 2;
  localparam logic [1:0] TXM_CHAR = 2'h0;
  localparam logic [1:0] TXM_DONE = 2'h1;
  localparam logic [1:0] TXM_EMPTY = 2'h2;
  localparam logic [1:0] RXM_3Q = 2'h2;
  localparam logic [1:0] RXM_FULL = 2'h3;
  localparam int BUF_DEPTH = 4;
  localparam logic [2:0] BUF_FULL = 3'h4;
  localparam logic [2:0] BUF_3Q = 3'h3;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] IR_SLOTS = 4'h3;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BRK_BITS = 4'hC;
  localparam logic [15:0] DIV_RESET = 16'h0014;
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} usc_frame_t;
endpackage

// File: hw/usc_line_if.sv
// Signals between the control core and its two line engines
`timescale 1ns/1ps
interface usc_line_if;
  logic tick;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic tx_brk;
  logic tx_abort;
  logic tx_busy;
  logic tx_done;
  logic tx_brk_act;
  logic tx_raw;
  logic tx_slot;
  logic rx_line;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_rx_framing_error;
  logic rx_idle;
  modport core(output tick, tx_valid, tx_data, tx_brk, tx_abort, rx_line,
    input tx_ready, tx_busy, tx_done, tx_brk_act, tx_raw, tx_slot,
    input rx_valid, rx_data, rx_rx_framing_error, rx_idle);
  modport txe(input tick, tx_valid, tx_data, tx_brk, tx_abort,
    output tx_ready, tx_busy, tx_done, tx_brk_act, tx_raw, tx_slot);
  modport rxe(input tick, rx_line,
    output rx_valid, rx_data, rx_rx_framing_error, rx_idle);
endinterface

// File: hw/usc_tx_engine.sv
// Transmit shifter: start, data or break bits, stop, at 16 ticks a bit
`timescale 1ns/1ps
module usc_tx_engine import usc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  usc_line_if.txe lnk
);
  usc_frame_t st_r;
  logic [3:0] tk_r;
  logic [3:0] bit_r;
  logic [3:0] nb_r;
  logic [11:0] sh_r;
  logic brk_r;
  wire bit_end = lnk.tick && tk_r == OVS_LAST;
  wire load = lnk.tx_valid && st_r == S_IDLE;
  assign lnk.tx_ready = st_r == S_IDLE;
  assign lnk.tx_busy = st_r != S_IDLE;
  assign lnk.tx_brk_act = brk_r;
  assign lnk.tx_slot = tk_r < IR_SLOTS;
  assign lnk.tx_done = bit_end && st_r == S_STOP;
  assign lnk.tx_raw = st_r == S_START ? 1'b0 :
                      st_r == S_DATA ? sh_r[0] : 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      tk_r <= 4'h0;
      bit_r <= 4'h0;
      nb_r <= 4'h0;
      sh_r <= 12'h000;
      brk_r <= 1'b0;
    end else if (lnk.tx_abort) begin
      st_r <= S_IDLE;
      tk_r <= 4'h0;
      brk_r <= 1'b0;
    end else if (load) begin
      // A break frame swallows the queued character as a dummy
      st_r <= S_START;
      tk_r <= 4'h0;
      bit_r <= 4'h0;
      brk_r <= lnk.tx_brk;
      nb_r <= lnk.tx_brk ? BRK_BITS : DATA_BITS;
      sh_r <= lnk.tx_brk ? 12'h000 : {4'h0, lnk.tx_data};
    end else if (lnk.tick && st_r != S_IDLE) begin
      tk_r <= tk_r + 4'h1;
      if (bit_end) begin
        unique case (st_r)
          S_IDLE: ;
          S_START: st_r <= S_DATA;
          S_DATA: begin
            sh_r <= {1'b0, sh_r[11:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == nb_r - 4'h1) st_r <= S_STOP;
          end
          S_STOP: begin
            st_r <= S_IDLE;
            brk_r <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// File: hw/usc_rx_engine.sv
// Receive shifter: mid-bit sampling of an 8N1 frame at 16 ticks a bit
`timescale 1ns/1ps
module usc_rx_engine import usc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  usc_line_if.rxe lnk
);
  usc_frame_t st_r;
  logic [3:0] tk_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic vld_r;
  logic rx_framing_error_r;
  wire smp_mid = lnk.tick && tk_r == OVS_MID;
  wire smp_end = lnk.tick && tk_r == OVS_LAST;
  assign lnk.rx_valid = vld_r;
  assign lnk.rx_data = sh_r;
  assign lnk.rx_rx_framing_error = rx_framing_error_r;
  assign lnk.rx_idle = st_r == S_IDLE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      tk_r <= 4'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      vld_r <= 1'b0;
      rx_framing_error_r <= 1'b0;
    end else begin
      vld_r <= 1'b0;
      if (lnk.tick) tk_r <= tk_r + 4'h1;
      unique case (st_r)
        S_IDLE: begin
          tk_r <= 4'h0;
          bit_r <= 4'h0;
          if (!lnk.rx_line) st_r <= S_START;
        end
        S_START: begin
          // A glitch shorter than half a bit is dropped here
          if (smp_mid) begin
            tk_r <= 4'h0;
            st_r <= lnk.rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (smp_end) begin
            sh_r <= {lnk.rx_line, sh_r[7:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == DATA_BITS - 4'h1) st_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (smp_end) begin
            vld_r <= 1'b1;
            rx_framing_error_r <= !lnk.rx_line;
            st_r <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: test/usc_remote.sv
// Far-end serial transceiver model: decodes the line, sends frames back
`timescale 1ns/1ps
module usc_remote (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  // The bench runs the divider at 0, so one bit lasts 16 clocks
  localparam int BITLEN = 16;
  logic [7:0] rxq[$];
  logic [7:0] sh;
  int run_len = 0;
  int last_low = 0;
  initial line_out = 1'h1;
  // Plain 8N1 only; infrared frames are not decoded here
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BITLEN) @(posedge pclk);
    end
  endtask
  initial forever begin
    do @(posedge pclk); while (line_in !== 1'h0);
    repeat (BITLEN / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BITLEN) @(posedge pclk);
      if (i < 8) sh[i] = line_in;
    end
    if (line_in === 1'h1) rxq.push_back(sh);
    // A break or a stuck line: wait for idle before hunting a new start
    while (line_in !== 1'h1) @(posedge pclk);
  end
  always @(posedge pclk) begin
    if (line_in === 1'h0) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_low <= run_len;
      run_len <= 0;
    end
  end
endmodule

// File: test/usc_top_tb_top.sv
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
module usc_top_tb_top import usc_pkg::*; ;
  localparam logic [31:0] EN = 32'h00000400;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, rx_line, tx_pin, tx_oe, irq, tx_line, rd_e;
  logic [1:0] tm;
  int thr;
  int n_errors = 0;
  int comparisons = 0;

  always #12.5 pclk = ~pclk;
  // Pull-up holds the line high whenever the port lets go of it
  assign tx_line = tx_oe ? tx_pin : 1'h1;

  usc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_line), .serial_tx_pin(tx_pin),
    .serial_tx_oe(tx_oe), .irq(irq));
  usc_remote far (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got,
        exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    if (n >= 64) begin
      n_errors++;
      print_verdict();
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'h0, 32'h00000000);
  endtask
  // Polls over the bus so a stuck shifter ends in a report, not a hang
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFF_STA);
      n++;
    end while (rd_q[B_TX_SHIFT_EMPTY] !== 1'h1 && n < 400);
    if (n >= 400) begin
      n_errors++;
      print_verdict();
    end
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd(OFF_STA);
    chk(rd_q, 32'h00000110, "status reset");
    rd(OFF_CTL);
    chk(rd_q, {16'h0000, DIV_RESET}, "divider reset");
    // Divider 0 gives 16 clocks a bit, the rate the far-end model decodes
    wr(OFF_CTL, 32'h00000000);
    rd(8'h18);
    chk(rd_e, 1'h1, "unmapped error");
    wr(OFF_IMSK, 32'h00000007);
    wr(OFF_STA, EN);
    tk(2);
    chk(tx_oe, 1'h1, "oe on");
    // Three chars: the middle load tells mode 00 from 10 and 01
    for (int m = 0; m < 3; m++) begin
      tm = 2'(m);
      wr(OFF_STA, EN | {16'h0000, tm[1], 1'h0, tm[0], 13'h0000});
      for (int k = 0; k < 3; k++) wr(OFF_TXD, 32'h000000C0);
      wr(OFF_IST, 32'h00000007);
      tk(200);
      rd(OFF_IST);
      chk(rd_q[IRQ_TX], tm == TXM_CHAR, "tx event mid");
      chk(irq, tm == TXM_CHAR, "irq mid");
      wait_idle();
      tk(4);
      rd(OFF_IST);
      chk(rd_q[IRQ_TX], 1'h1, "tx event end");
      wr(OFF_IST, 32'h00000007);
    end
    far.rxq.delete();
    for (int k = 0; k < 6; k++) begin
      wr(OFF_TXD, 32'h000000A0 + 32'(k));
      if (k == 4) begin
        rd(OFF_STA);
        chk(rd_q[9:8], 2'h2, "full busy");
      end
    end
    wait_idle();
    rd(OFF_STA);
    chk(rd_q[9:8], 2'h1, "drained");
    chk(far.rxq.size(), 5, "sent count");
    for (int k = 0; k < 5; k++) chk(far.rxq[k], 8'hA0 + 8'(k), "sent");
    wr(OFF_STA, EN | 32'h00000800);
    wr(OFF_TXD, 32'h00000055);
    wait_idle();
    tk(20);
    chk(far.last_low, 32'(13 * 16), "break low time");
    rd(OFF_STA);
    chk(rd_q[B_BRK], 1'h0, "break cleared");
    for (int m = 0; m < 4; m++) begin
      thr = (m == 3) ? 4 : (m == 2) ? 3 : 1;
      wr(OFF_STA, EN | (32'(m) << 6));
      wr(OFF_IST, 32'h00000007);
      for (int k = 0; k < thr; k++) begin
        rd(OFF_IST);
        chk(rd_q[IRQ_RX], 1'h0, "rx early");
        far.send(8'h30 + 8'(k));
        tk(6);
      end
      rd(OFF_IST);
      chk(rd_q[IRQ_RX], 1'h1, "rx event");
      for (int k = 0; k < thr; k++) begin
        rd(OFF_RXD);
        chk(rd_q[7:0], 8'h30 + 8'(k), "rx byte");
      end
    end
    wr(OFF_STA, EN);
    wr(OFF_IST, 32'h00000007);
    for (int k = 0; k < 5; k++) far.send(8'h40 + 8'(k));
    tk(6);
    rd(OFF_STA);
    chk(rd_q[1:0], 2'h3, "overrun set");
    rd(OFF_IST);
    chk(rd_q[IRQ_OVR], 1'h1, "overrun event");
    wr(OFF_STA, EN | 32'h00000002);
    rd(OFF_STA);
    chk(rd_q[B_RX_OVERRUN_FLAG], 1'h1, "write one kept");
    wr(OFF_STA, EN);
    rd(OFF_STA);
    chk(rd_q[B_RX_OVERRUN_FLAG], 1'h0, "write zero clears");
    for (int k = 0; k < 4; k++) begin
      rd(OFF_RXD);
      chk(rd_q[7:0], 8'h40 + 8'(k), "held byte");
    end
    chk(irq, 1'h1, "irq raised");
    wr(OFF_IMSK, 32'h00000000);
    tk(1);
    chk(irq, 1'h0, "irq masked");
    wr(OFF_IMSK, 32'h00000007);
    wr(OFF_IST, 32'h00000007);
    tk(1);
    chk(irq, 1'h0, "irq cleared");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTL, i[1] ? 32'h00010000 : 32'h00000000);
      wr(OFF_STA, i[0] ? EN | 32'h00004000 : EN);
      tk(4);
      chk(tx_pin, i[1] ? i[0] : !i[0], "idle level");
    end
    wr(OFF_CTL, 32'h00000000);
    wr(OFF_STA, EN);
    tk(40);
    for (int k = 0; k < 3; k++) wr(OFF_TXD, 32'h00000011);
    tk(30);
    wr(OFF_STA, 32'h00000000);
    tk(2);
    chk(tx_oe, 1'h0, "oe off");
    rd(OFF_STA);
    chk(rd_q[9:8], 2'h1, "flushed");
    wr(OFF_STA, EN);
    tk(30);
    rd(OFF_STA);
    chk(rd_q[B_TX_SHIFT_EMPTY], 1'h1, "nothing left");
    print_verdict();
  end
endmodule
